// File: hdl/flash_writer_pkg.sv
package flash_writer_pkg;
  // ****************************************
  // register map, byte addresses on the bus
  // ****************************************
  localparam logic [4:0] OFF_ADDR_LOW = 5'h00;
  localparam logic [4:0] OFF_ADDR_HIGH = 5'h04;
  localparam logic [4:0] OFF_DATA_LOW = 5'h08;
  localparam logic [4:0] OFF_DATA_HIGH = 5'h0c;
  localparam logic [4:0] OFF_CONTROL = 5'h10;

  // ****************************************
  // control register bit positions
  // ****************************************
  localparam int BIT_RD = 0;
  localparam int BIT_WR = 1;
  localparam int BIT_WREN = 2;
  localparam int BIT_WRERR = 3;
  localparam int BIT_ERASE = 4;
  localparam int BIT_LWLO = 5;
  localparam int BIT_CFG_SEL = 6;
  localparam int BIT_PGD = 7;

  // ****************************************
  // geometry and values
  // ****************************************
  localparam int WORD_W = 14;
  localparam int ADDR_W = 13;
  localparam int ROW_BITS = 5;
  localparam logic [ROW_BITS-1:0] ROW_LAST = 5'h1f;
  localparam logic [WORD_W-1:0] ERASED_WORD = 14'h3fff;
  localparam logic [WORD_W-1:0] LATCH_RESET = 14'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // write-protect field codes
  localparam logic [1:0] WP_ALL = 2'h0;
  localparam logic [1:0] WP_HALF = 2'h1;
  localparam logic [1:0] WP_QUARTER = 2'h2;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD_WAIT = 3'b001,
    ST_RD_ACC = 3'b010,
    ST_RD_DONE = 3'b011,
    ST_ERASE = 3'b100,
    ST_PROG = 3'b101
  } seq_state_t;
endpackage

// File: hdl/flash_array.sv
`timescale 1ns/1ns
// single-port program store, read data registered
module flash_array #(
  parameter int DATA_W = 14,
  parameter int AW = 13
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // access port
  input wire logic en,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata_r
);
  logic [DATA_W-1:0] mem [0:(1<<AW)-1];

  // array has no reset, like real flash cells
  always_ff @(posedge core_clk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
  end

  // read data held until the next read
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_r <= '0;
    end else if (en && !we) begin
      rdata_r <= mem[addr];
    end
  end
endmodule

// File: hdl/program_flash_row_writer.sv
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
// Overview of operation
// - rows of 14-bit words; erase whole row
// - no erase or program when protected
// - program whole row or any subset
// - hidden latches filled through data pair
// - access second cycle, data next cycle
// - data pair holds until read or write
// - row and latch set span 32 words
module program_flash_row_writer
  import flash_writer_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // configuration words
  input wire logic [1:0] write_protect_field,
  // core side
  output logic stall_core
);
  // ****************************************
  // register state
  // ****************************************
  logic ack_r;
  logic [31:0] rdata_r;
  logic [7:0] prog_addr_low_r;
  logic [AW-9:0] prog_addr_high_r;
  logic [7:0] prog_data_low_r;
  logic [WORD_W-9:0] prog_data_high_r;
  logic wren_r, wrerr_r, erase_r, lwlo_r, cfg_sel_r, pgd_r;
  seq_state_t state_r, state_nxt;
  logic [ROW_BITS-1:0] idx_r, idx_nxt;
  logic [WORD_W-1:0] latch_r [0:(1<<ROW_BITS)-1];
  logic [(1<<ROW_BITS)-1:0] latch_valid_r;
  logic [WORD_W-1:0] mem_rdata;

  // ****************************************
  // bus decode
  // ****************************************
  // one wait state on every access keeps read data registered
  wire req = avs_read | avs_write;
  wire wr_acc = avs_write & ack_r & avs_byteenable[0];
  wire [7:0] wb = avs_writedata[7:0];
  wire idle = (state_r == ST_IDLE);
  wire sel_alo = (avs_address == OFF_ADDR_LOW);
  wire sel_ahi = (avs_address == OFF_ADDR_HIGH);
  wire sel_dlo = (avs_address == OFF_DATA_LOW);
  wire sel_dhi = (avs_address == OFF_DATA_HIGH);
  wire sel_ctl = (avs_address == OFF_CONTROL);
  // address and control only change while the sequencer is idle
  wire addr_lo_we = wr_acc & sel_alo & idle;
  wire addr_hi_we = wr_acc & sel_ahi & idle;
  wire data_lo_we = wr_acc & sel_dlo;
  wire data_hi_we = wr_acc & sel_dhi;
  wire ctl_we = wr_acc & sel_ctl & idle;
  wire rd_busy = (state_r == ST_RD_WAIT) | (state_r == ST_RD_ACC) | (state_r == ST_RD_DONE);
  wire op_active = (state_r == ST_ERASE) | (state_r == ST_PROG);
  wire [7:0] ctl_view = {pgd_r, cfg_sel_r, lwlo_r, erase_r, wrerr_r, wren_r, op_active, rd_busy};
  wire [31:0] rd_mux = sel_alo ? {24'h000000, prog_addr_low_r} :
                       sel_ahi ? {{(40-AW){1'b0}}, prog_addr_high_r} :
                       sel_dlo ? {24'h000000, prog_data_low_r} :
                       sel_dhi ? {{(40-WORD_W){1'b0}}, prog_data_high_r} :
                       sel_ctl ? {24'h000000, ctl_view} : 32'h00000000;
  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata = rdata_r;

  // ****************************************
  // command decode
  // ****************************************
  wire [AW-1:0] full_addr = {prog_addr_high_r, prog_addr_low_r};
  wire [AW-ROW_BITS-1:0] row_sel = full_addr[AW-1:ROW_BITS];
  wire [ROW_BITS-1:0] lat_idx = prog_addr_low_r[ROW_BITS-1:0];
  wire space_ok = wb[BIT_PGD] & ~wb[BIT_CFG_SEL];
  wire start_rd = ctl_we & wb[BIT_RD];
  wire start_wr = ctl_we & wb[BIT_WR] & wb[BIT_WREN] & ~wb[BIT_RD];
  wire prot = (write_protect_field == WP_ALL) |
              ((write_protect_field == WP_HALF) & ~full_addr[AW-1]) |
              ((write_protect_field == WP_QUARTER) & (full_addr[AW-1:AW-2] == 2'h0));
  wire rd_go = start_rd & space_ok;
  // a program command (erase bit clear) first stores the data pair in a latch
  wire load = start_wr & ~wb[BIT_ERASE] & space_ok;
  wire go_prog = load & ~wb[BIT_LWLO] & ~prot;
  wire go_erase = start_wr & wb[BIT_ERASE] & space_ok & ~prot;
  // refused commands flag an error; a protected program command still loads its latch
  wire refuse = start_wr & ~space_ok |
                start_wr & space_ok & prot & (wb[BIT_ERASE] | ~wb[BIT_LWLO]);
  wire prog_done = (state_r == ST_PROG) & (idx_r == ROW_LAST);

  // ****************************************
  // memory port
  // ****************************************
  // erase writes blank words across the row
  wire mem_en = (state_r == ST_RD_ACC) | op_active;
  // unloaded latches leave their words alone
  wire mem_we = (state_r == ST_ERASE) | ((state_r == ST_PROG) & latch_valid_r[idx_r]);
  // row base with five low bits from the step counter
  wire [AW-1:0] mem_addr = op_active ? {row_sel, idx_r} : full_addr;
  wire [WORD_W-1:0] mem_wdata = (state_r == ST_ERASE) ? ERASED_WORD : latch_r[idx_r];
  // core loses the instruction in the access cycle
  assign stall_core = (state_r == ST_RD_ACC);

  flash_array #(
    .DATA_W(WORD_W),
    .AW(AW)
  ) u_array (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .en(mem_en),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata_r(mem_rdata)
  );

  // ****************************************
  // bus handshake
  // ****************************************
  // answer at the second edge of every request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req && !ack_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // address pair and control bits
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prog_addr_low_r <= BYTE_RESET;
      prog_addr_high_r <= '0;
      {wren_r, erase_r, lwlo_r, cfg_sel_r, pgd_r} <= 5'h00;
    end else begin
      if (addr_lo_we) begin
        prog_addr_low_r <= wb;
      end
      if (addr_hi_we) begin
        prog_addr_high_r <= wb[AW-9:0];
      end
      if (ctl_we) begin
        {pgd_r, cfg_sel_r, lwlo_r, erase_r} <= wb[BIT_PGD:BIT_ERASE];
        wren_r <= wb[BIT_WREN];
      end
    end
  end

  // error flag: a refusal wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrerr_r <= 1'b0;
    end else if (refuse) begin
      wrerr_r <= 1'b1;
    end else if (ctl_we && !wb[BIT_WRERR]) begin
      wrerr_r <= 1'b0;
    end
  end

  // data pair changes only on software write or finished read
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prog_data_low_r <= BYTE_RESET;
      prog_data_high_r <= '0;
    end else begin
      if (data_lo_we) begin
        prog_data_low_r <= wb;
      end else if (state_r == ST_RD_DONE) begin
        prog_data_low_r <= mem_rdata[7:0];
      end
      if (data_hi_we) begin
        prog_data_high_r <= wb[WORD_W-9:0];
      end else if (state_r == ST_RD_DONE) begin
        prog_data_high_r <= mem_rdata[WORD_W-1:8];
      end
    end
  end

  // one hidden latch per row word
  for (genvar i = 0; i < (1 << ROW_BITS); i++) begin : g_latch
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        latch_r[i] <= LATCH_RESET;
        latch_valid_r[i] <= 1'b0;
      end else if (load && lat_idx == ROW_BITS'(i)) begin
        latch_r[i] <= {prog_data_high_r, prog_data_low_r};
        latch_valid_r[i] <= 1'b1;
      end else if (prog_done) begin
        latch_valid_r[i] <= 1'b0;
      end
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      idx_r <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
    end
  end

  // read takes wait, access, then capture
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    case (state_r)
      ST_IDLE: begin
        idx_nxt = '0;
        if (rd_go) begin
          state_nxt = ST_RD_WAIT;
        end else if (go_erase) begin
          state_nxt = ST_ERASE;
        end else if (go_prog) begin
          state_nxt = ST_PROG;
        end
      end
      ST_RD_WAIT: state_nxt = ST_RD_ACC;
      ST_RD_ACC: state_nxt = ST_RD_DONE;
      ST_RD_DONE: state_nxt = ST_IDLE;
      ST_ERASE, ST_PROG: begin
        idx_nxt = idx_r + 5'h01;
        if (idx_r == ROW_LAST) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_ERASE_ROW: assert property (
    (state_r == ST_ERASE) |-> mem_we && mem_wdata == ERASED_WORD &&
      mem_addr[AW-1:ROW_BITS] == row_sel)
    else $error("erase left its row or wrote a non-blank word");
  AST_PROTECT: assert property (
    (ctl_we && start_wr && prot && !wb[BIT_LWLO]) |=> state_r == ST_IDLE && wrerr_r)
    else $error("protected segment was not refused");
  AST_SUBSET: assert property (
    (state_r == ST_PROG && !latch_valid_r[idx_r]) |-> !mem_we)
    else $error("unloaded latch was programmed");
  AST_LATCH_LOAD: assert property (
    load |=> latch_valid_r[$past(lat_idx)] &&
      latch_r[$past(lat_idx)] == $past({prog_data_high_r, prog_data_low_r}))
    else $error("latch did not take the data pair");
  AST_READ_TIMING: assert property (
    rd_go |=> state_r == ST_RD_WAIT && !stall_core ##1 stall_core && mem_en
      ##1 state_r == ST_RD_DONE ##1 {prog_data_high_r, prog_data_low_r} == $past(mem_rdata))
    else $error("read sequence timing wrong");
  AST_DATA_HOLD: assert property (
    (!data_lo_we && !data_hi_we && state_r != ST_RD_DONE) |=>
      $stable({prog_data_high_r, prog_data_low_r}))
    else $error("data pair changed without cause");
  AST_ROW_SPAN: assert property (
    ((go_erase || go_prog) && idle) |=> op_active [*8] ##24 op_active ##1 idle)
    else $error("row operation did not last 32 cycles");

  COV_ERASE: cover property (go_erase ##1 (state_r == ST_ERASE) [*8]);
  COV_PROG_PARTIAL: cover property ((state_r == ST_PROG) && !latch_valid_r[idx_r]);
  COV_READ: cover property (rd_go ##3 state_r == ST_RD_DONE);
  COV_REFUSE: cover property (refuse);
endmodule

// File: sim/program_flash_row_writer_tb.sv
`timescale 1ns/1ns
module program_flash_row_writer_tb;
  import flash_writer_pkg::*;
  // ****************************************
  // stimulus and observation
  // ****************************************
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [1:0] write_protect_field = 2'h3;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic stall_core;
  int fails = 0;
  int tests_run = 0;

  program_flash_row_writer dut_u (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .write_protect_field(write_protect_field),
    .stall_core(stall_core)
  );

  // 10 mhz core clock
  initial begin
    forever #50 core_clk = ~core_clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {24'h0, d};
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask

  task automatic rdreg(input logic [4:0] a, output logic [31:0] q);
    bus(1'b1, a, 8'h00, q);
  endtask

  task automatic set_addr(input logic [12:0] a);
    wr(OFF_ADDR_LOW, a[7:0]);
    wr(OFF_ADDR_HIGH, {3'h0, a[12:8]});
  endtask

  // polls until neither read nor write is busy; bounded
  task automatic ctl_wait();
    logic [31:0] c;
    int n;
    n = 0;
    do begin
      rdreg(OFF_CONTROL, c);
      n++;
    end while (c[1:0] !== 2'h0 && n < 40);
    if (n >= 40) begin
      fails++;
      summarize();
    end
  endtask

  task automatic rd_word(input logic [12:0] a, output logic [13:0] w);
    logic [31:0] lo;
    logic [31:0] hi;
    set_addr(a);
    wr(OFF_CONTROL, 8'h80);
    wr(OFF_CONTROL, 8'h81);
    ctl_wait();
    rdreg(OFF_DATA_LOW, lo);
    rdreg(OFF_DATA_HIGH, hi);
    w = {hi[5:0], lo[7:0]};
  endtask

  task automatic chk_word(input logic [12:0] a, input logic [13:0] exp);
    logic [13:0] w;
    rd_word(a, w);
    chk({18'h0, w}, {18'h0, exp});
  endtask

  // last=0 only loads a latch; last=1 also programs the row
  task automatic put_word(input logic [12:0] a, input logic [13:0] w, input logic last);
    set_addr(a);
    wr(OFF_DATA_LOW, w[7:0]);
    wr(OFF_DATA_HIGH, {2'h0, w[13:8]});
    wr(OFF_CONTROL, last ? 8'h86 : 8'ha6);
    ctl_wait();
  endtask

  task automatic erase(input logic [12:0] a);
    set_addr(a);
    wr(OFF_CONTROL, 8'h96);
    ctl_wait();
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [31:0] q;
    rdreg(OFF_CONTROL, q);
    chk(q, 32'h0);
    rdreg(OFF_DATA_LOW, q);
    chk(q, 32'h0);
    rdreg(5'h14, q);
    chk(q, 32'h0);
  endtask

  // two latches then a second fill cycle into the same erased row
  task automatic t_subset();
    erase(13'h0040);
    put_word(13'h0042, 14'h1234, 1'b0);
    put_word(13'h005f, 14'h2abc, 1'b1);
    chk_word(13'h0042, 14'h1234);
    chk_word(13'h005f, 14'h2abc);
    chk_word(13'h0043, ERASED_WORD);
    put_word(13'h0043, 14'h0555, 1'b1);
    chk_word(13'h0043, 14'h0555);
    chk_word(13'h0042, 14'h1234);
  endtask

  // every protection code against a row at 0x800, next row as a fence
  task automatic t_protect();
    logic [31:0] c;
    logic prot;
    for (int k = 0; k < 4; k++) begin
      prot = (k < 2);
      @(posedge core_clk);
      write_protect_field <= 2'h3;
      put_word(13'h0801, 14'h0a50 + 14'(k), 1'b0);
      put_word(13'h081f, 14'h1a50 + 14'(k), 1'b1);
      put_word(13'h0820, 14'h1111, 1'b1);
      @(posedge core_clk);
      write_protect_field <= 2'(k);
      erase(13'h0800);
      rdreg(OFF_CONTROL, c);
      chk({31'h0, c[BIT_WRERR]}, {31'h0, prot});
      wr(OFF_CONTROL, 8'h00);
      chk_word(13'h0801, prot ? 14'h0a50 + 14'(k) : ERASED_WORD);
      chk_word(13'h081f, prot ? 14'h1a50 + 14'(k) : ERASED_WORD);
      chk_word(13'h0820, 14'h1111);
    end
    @(posedge core_clk);
    write_protect_field <= 2'h3;
  endtask

  // stall lands on the second cycle after the strobe, then data holds
  task automatic t_read_timing();
    logic [31:0] q;
    set_addr(13'h0043);
    wr(OFF_CONTROL, 8'h80);
    wr(OFF_CONTROL, 8'h81);
    #1;
    chk({31'h0, stall_core}, 32'h0);
    @(posedge core_clk);
    #1;
    chk({31'h0, stall_core}, 32'h1);
    @(posedge core_clk);
    #1;
    chk({31'h0, stall_core}, 32'h0);
    @(posedge core_clk);
    rdreg(OFF_DATA_LOW, q);
    chk(q, 32'h55);
    wr(OFF_ADDR_LOW, 8'h00);
    rdreg(OFF_DATA_HIGH, q);
    chk(q, 32'h05);
    wr(OFF_DATA_LOW, 8'h3c);
    rdreg(OFF_DATA_LOW, q);
    chk(q, 32'h3c);
  endtask

  // partial change of a used row: save, erase, write back
  task automatic t_resave();
    logic [13:0] keep_lo;
    logic [13:0] keep_hi;
    rd_word(13'h0042, keep_lo);
    rd_word(13'h005f, keep_hi);
    erase(13'h0040);
    put_word(13'h0042, keep_lo, 1'b0);
    put_word(13'h0043, 14'h0aaa, 1'b0);
    put_word(13'h005f, keep_hi, 1'b1);
    chk_word(13'h0042, 14'h1234);
    chk_word(13'h0043, 14'h0aaa);
    chk_word(13'h005f, 14'h2abc);
    chk_word(13'h0044, ERASED_WORD);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    $display("reset test done");
    t_subset();
    $display("subset test done");
    t_protect();
    $display("protect test done");
    t_read_timing();
    $display("read timing test done");
    t_resave();
    $display("resave test done");
    summarize();
  end

  // whole run needs under two thousand cycles; allow 40000
  initial begin
    #(100 * 40000);
    fails++;
    summarize();
  end
endmodule
